// ==== core/rbcs_core.sv ====
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - external reset low holds all logic in reset
// - internal reset releases synchronously after a fixed clock count
// - reset output pin always follows internal reset state
// - power-on reset asserts automatically at power-up
// - reset pin bit in pull-up disable register turns off its pull-up
// - boot strap high and flash unsecured boots external, else internal
// - both boot straps are tied low inside the package
// - normally boot internal; source also depends on strap and security
// - oscillator level bit resets to zero; zero for ceramic resonator
// - no relaxation oscillator and no controls for one
// - strap high with flash secured is ignored, internal boot
module rbcs_core
    import rbcs_pkg::*;
#(
    parameter int RELEASE_CYCLES = RBCS_RELEASE_CYCLES,
    parameter int POR_CYCLES     = RBCS_POR_CYCLES
)(
    input  wire logic        clk_i,            // internal clock
    input  wire logic        rst_n_i,          // external reset, active low
    input  wire logic        por_n_i,          // power-on reset, active low
    input  wire logic        trst_n_i,         // test reset, observed only
    input  wire logic        flash_secured_i,  // flash security state
    input  wire logic [3:0]  addr_i,           // register index
    input  wire logic [15:0] wdata_i,          // write data
    input  wire logic        we_i,             // write strobe
    input  wire logic        re_i,             // read strobe
    output logic      [15:0] rdata_o,          // read data, next cycle
    output logic             sys_rst_n_o,      // internal reset, active low
    output logic             reset_output_pin_o, // reset output, high = reset
    output logic             reset_pullup_en_o,  // reset pin pull-up enable
    output logic             boot_pullup_en_o,   // boot strap pull-up enable
    output logic             emi_pullup_en_o,    // memory strap pull-up enable
    output logic             boot_external_o,  // mode a: external boot
    output logic             flash_unsecure_o, // mode b: flash not secured
    output logic             oscillator_level_select_o // high-level osc mode
);
    localparam int CW = $clog2(RELEASE_CYCLES + POR_CYCLES + 2);

    logic external_boot_strap;
    logic external_memory_mode_strap;
    assign external_boot_strap        = 1'b0;
    assign external_memory_mode_strap = 1'b0;

    logic any_rst_n;
    assign any_rst_n = rst_n_i & por_n_i;

    typedef enum logic [2:0] {
        RBCS_S_HOLD  = 3'b001,
        RBCS_S_COUNT = 3'b010,
        RBCS_S_RUN   = 3'b100
    } rbcs_state_t;

    rbcs_state_t state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic sync1_q, sync2_q;

    // two-flop release of the combined reset
    always_ff @(posedge clk_i or negedge any_rst_n)
    begin
        if (!any_rst_n)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= 1'b1;
            sync2_q <= sync1_q;
        end
    end

    // release sequencer next state
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            RBCS_S_HOLD:
            begin
                cnt_d = '0;
                if (sync2_q)
                    state_d = RBCS_S_COUNT;
            end
            RBCS_S_COUNT:
            begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CW'(RELEASE_CYCLES - 1))
                    state_d = RBCS_S_RUN;
            end
            RBCS_S_RUN:
            begin
                cnt_d = cnt_q;
            end
            default:
            begin
                state_d = RBCS_S_HOLD;
                cnt_d   = '0;
            end
        endcase
    end

    // held in reset while external or power-on reset low
    always_ff @(posedge clk_i or negedge any_rst_n)
    begin
        if (!any_rst_n)
        begin
            state_q <= RBCS_S_HOLD;
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    logic run;
    assign run = (state_q == RBCS_S_RUN);

    assign sys_rst_n_o        = run;
    assign reset_output_pin_o = ~run;

    logic [2:0] pudr_q, pudr_d;
    logic       osc_q, osc_d;
    logic       ma_q, ma_d, mb_q, mb_d;
    logic [15:0] rdata_q, rdata_d;

    // register index match, shared by write and read decoding
    function automatic logic rbcs_hit(input logic [3:0] a,
                                      input logic [3:0] idx);
        return (a == idx);
    endfunction

    // register writes, boot latch and read mux
    always_comb
    begin
        pudr_d  = pudr_q;
        osc_d   = osc_q;
        ma_d    = ma_q;
        mb_d    = mb_q;
        rdata_d = rdata_q;
        // strap selects external boot when unsecured
        if (!run)
        begin
            mb_d = ~flash_secured_i;
            ma_d = external_boot_strap & ~flash_secured_i;
        end
        else if (we_i)
        begin
            // writes are refused until the sequencer runs
            if (rbcs_hit(addr_i, RBCS_ADDR_PUDR))
                pudr_d = wdata_i[2:0];
            else if (rbcs_hit(addr_i, RBCS_ADDR_OSC_CTRL))
                osc_d = wdata_i[RBCS_OSC_LEVEL_BIT];
        end
        if (re_i)
        begin
            if (rbcs_hit(addr_i, RBCS_ADDR_PUDR))
                rdata_d = {13'h0000, pudr_q};
            else if (rbcs_hit(addr_i, RBCS_ADDR_OSC_CTRL))
                rdata_d = {15'h0000, osc_q};
            else if (rbcs_hit(addr_i, RBCS_ADDR_BOOT))
                rdata_d = {13'h0000, external_memory_mode_strap, mb_q, ma_q};
            else if (rbcs_hit(addr_i, RBCS_ADDR_STAT))
                rdata_d = {13'h0000, trst_n_i, sync2_q, run};
            else
                rdata_d = RBCS_ZERO16;
        end
        else
            rdata_d = RBCS_ZERO16;
    end

    always_ff @(posedge clk_i or negedge any_rst_n)
    begin
        if (!any_rst_n)
        begin
            pudr_q  <= RBCS_PUDR_RST_VAL;
            osc_q   <= RBCS_OSC_LEVEL_RST;
            ma_q    <= 1'b0;
            mb_q    <= 1'b0;
            rdata_q <= RBCS_ZERO16;
        end
        else
        begin
            pudr_q  <= pudr_d;
            osc_q   <= osc_d;
            ma_q    <= ma_d;
            mb_q    <= mb_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
    assign reset_pullup_en_o = ~pudr_q[RBCS_PUDR_RESET_BIT];
    assign boot_pullup_en_o  = ~pudr_q[RBCS_PUDR_BOOT_BIT];
    assign emi_pullup_en_o   = ~pudr_q[RBCS_PUDR_EMI_BIT];
    assign boot_external_o   = ma_q;
    assign flash_unsecure_o  = mb_q;
    assign oscillator_level_select_o = osc_q;

    // cycles spent counting since sync release
    logic [CW-1:0] since_q, since_d;
    always_comb
    begin
        since_d = since_q;
        if (sync2_q && !run)
            since_d = since_q + 1'b1;
    end

    // register the count, cleared by external or power-on reset
    always_ff @(posedge clk_i or negedge any_rst_n)
    begin
        if (!any_rst_n)
            since_q <= '0;
        else
            since_q <= since_d;
    end

    a_release_delay: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        $rose(run) |-> since_q == CW'(RELEASE_CYCLES + 1))
        else $error("release not after fixed count");
    a_pin_follow: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        reset_output_pin_o == ~sys_rst_n_o)
        else $error("reset output not mirroring");
    a_hold_reset: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        !sync2_q |-> reset_output_pin_o)
        else $error("reset dropped early");
    a_secure_boot: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        $rose(run) && $past(flash_secured_i) |-> !boot_external_o)
        else $error("external boot with secured flash");
    a_boot_internal: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        run |-> !boot_external_o)
        else $error("external boot with strap low");
    a_osc_reset: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        !run |-> !oscillator_level_select_o)
        else $error("osc level bit not zero in reset");
    a_osc_write: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        run && we_i && addr_i == RBCS_ADDR_OSC_CTRL |=>
        oscillator_level_select_o ==
        $past(wdata_i[RBCS_OSC_LEVEL_BIT]))
        else $error("osc level write lost");
    a_pullup_off: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        run && we_i && addr_i == RBCS_ADDR_PUDR && wdata_i[0] |=>
        !reset_pullup_en_o)
        else $error("reset pull-up not disabled");
    // mode b tracks security while held
    a_mode_latch: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        !run |=> flash_unsecure_o == ~$past(flash_secured_i))
        else $error("security state not latched");
    // second sync stage only after the first
    a_sync_order: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        sync2_q |-> sync1_q)
        else $error("sync stages out of order");
    // counter never passes the release count
    a_count_bound: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        state_q == RBCS_S_COUNT |-> cnt_q < CW'(RELEASE_CYCLES))
        else $error("release counter overran");
    // once released the core stays out of reset
    a_run_sticky: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        run |=> run)
        else $error("internal reset reasserted without cause");
    a_write_refused: assert property (@(posedge clk_i)
        disable iff (!any_rst_n)
        !run |=> $stable(oscillator_level_select_o))
        else $error("write taken during reset");
    a_pullup_held: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        !run |-> reset_pullup_en_o)
        else $error("reset pull-up off during reset");
    a_pullup_boot: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        run && we_i && addr_i == RBCS_ADDR_PUDR |=>
        boot_pullup_en_o == ~$past(wdata_i[RBCS_PUDR_BOOT_BIT]))
        else $error("boot pull-up write lost");
    a_mode_frozen: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        run |=> $stable(flash_unsecure_o))
        else $error("mode bit changed after release");
    a_emi_zero: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        re_i && addr_i == RBCS_ADDR_BOOT |=>
        !rdata_o[RBCS_BOOT_EMI_BIT])
        else $error("memory strap read as one");
    // level bit reads back as stored
    a_osc_readback: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        re_i && addr_i == RBCS_ADDR_OSC_CTRL |=>
        rdata_o == {15'h0000, $past(oscillator_level_select_o)})
        else $error("level bit read back wrong");
    // read data stands one cycle only
    a_rdata_idle: assert property (@(posedge clk_i) disable iff (!any_rst_n)
        !re_i |=> rdata_o == RBCS_ZERO16)
        else $error("read data not cleared");

    c_release: cover property (@(posedge clk_i) disable iff (!any_rst_n)
        $rose(run));
    c_osc_set: cover property (@(posedge clk_i) disable iff (!any_rst_n)
        $rose(oscillator_level_select_o));
    c_secured: cover property (@(posedge clk_i) disable iff (!any_rst_n)
        run && !flash_unsecure_o);
    c_unsecured: cover property (@(posedge clk_i) disable iff (!any_rst_n)
        run && flash_unsecure_o);
    c_pullup_off: cover property (@(posedge clk_i) disable iff (!any_rst_n)
        $fell(reset_pullup_en_o));
endmodule // rbcs_core
`default_nettype wire

// ==== core/rbcs_pkg.sv ====
package rbcs_pkg;
    // register indices on the plain register port
    localparam logic [3:0] RBCS_ADDR_PUDR   = 4'h0; // pull-up disable
    localparam logic [3:0] RBCS_ADDR_OSC_CTRL = 4'h1; // oscillator control
    localparam logic [3:0] RBCS_ADDR_BOOT   = 4'h2; // boot mode status
    localparam logic [3:0] RBCS_ADDR_STAT   = 4'h3; // reset status
    // pull-up disable register fields
    localparam int RBCS_PUDR_RESET_BIT = 0;
    localparam int RBCS_PUDR_BOOT_BIT  = 1;
    localparam int RBCS_PUDR_EMI_BIT   = 2;
    localparam logic [2:0] RBCS_PUDR_RST_VAL = 3'h0;
    // oscillator control fields
    localparam int RBCS_OSC_LEVEL_BIT = 0;
    localparam logic RBCS_OSC_LEVEL_RST = 1'b0;
    // boot status fields
    localparam int RBCS_BOOT_MA_BIT = 0;
    localparam int RBCS_BOOT_MB_BIT = 1;
    localparam int RBCS_BOOT_EMI_BIT = 2;
    // default release delay in internal clocks
    localparam int RBCS_RELEASE_CYCLES = 32;
    // power-on count in clocks, used only to size the release counter cnt_q and the since_q count
    localparam int RBCS_POR_CYCLES = 16;
    localparam logic [15:0] RBCS_ZERO16 = 16'h0000;
endpackage

// ==== verification/rbcs_board.sv ====
`timescale 1ns/10ps
`default_nettype none
// board reset network and debug host; lines move just after the clock edge
module rbcs_board (
    input  wire logic clk_i,    // board clock
    input  wire logic full_i,   // request a full hardware reset
    input  wire logic dbg_i,    // request a device-only reset
    input  wire logic pwr_i,    // supply just applied
    output logic      rst_n_o,  // device reset, active low
    output logic      trst_n_o, // test reset, active low
    output logic      por_n_o   // power-on reset, active low
);
    // debug reset keeps test reset off
    always @(posedge clk_i)
    begin
        rst_n_o  <= ~(full_i | dbg_i);
        trst_n_o <= ~full_i;
        por_n_o  <= ~pwr_i;
    end
endmodule // rbcs_board
`default_nettype wire

// ==== verification/rbcs_core_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module rbcs_core_tb;
    import rbcs_pkg::*;
    localparam int RC = 4; // shortened release count
    logic        clk_i = 1'b0;
    logic        full = 1'b1, dbg = 1'b0, pwr = 1'b1, sec = 1'b1;
    logic        we = 1'b0, re = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, d;
    wire logic   rst_n, trst_n, por_n;
    logic        sys_n, rso, pu_r, pu_b, pu_e, bext, funs, osc;
    int          errors = 0, samples_checked = 0, cycles = 0, n;

    // bench clock and hang guard
    initial forever #2 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            end_of_test();
        end
    end

    rbcs_board board (.clk_i(clk_i), .full_i(full), .dbg_i(dbg),
        .pwr_i(pwr), .rst_n_o(rst_n), .trst_n_o(trst_n), .por_n_o(por_n));
    rbcs_core #(.RELEASE_CYCLES(RC)) dut (.clk_i(clk_i), .rst_n_i(rst_n),
        .por_n_i(por_n), .trst_n_i(trst_n), .flash_secured_i(sec),
        .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
        .rdata_o(rdata), .sys_rst_n_o(sys_n), .reset_output_pin_o(rso),
        .reset_pullup_en_o(pu_r), .boot_pullup_en_o(pu_b),
        .emi_pullup_en_o(pu_e), .boot_external_o(bext),
        .flash_unsecure_o(funs), .oscillator_level_select_o(osc));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr <= a;
        wdata <= v;
        we <= 1'b1;
        @(posedge clk_i);
        we <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_i);
        addr <= a;
        re <= 1'b1;
        @(posedge clk_i);
        re <= 1'b0;
        #1 v = rdata;
    endtask

    // drop every reset request and count edges until the core runs
    task automatic release_all();
        @(posedge clk_i);
        full <= 1'b0;
        dbg <= 1'b0;
        pwr <= 1'b0;
        wait (rst_n && por_n);
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
            #1;
        end while (!sys_n && n < 100);
    endtask

    task automatic t_power_up();
        repeat (16) @(posedge clk_i);
        #1 check({rso, sys_n, pu_r, pu_b, pu_e, osc}, 16'h002e);
        rd(4'h3, d);
        check(d & 16'h0004, 16'h0000);
        release_all();
        check(16'(n), 16'(RC + 3));
        check({15'h0, rso}, 16'h0000);
        rd(RBCS_ADDR_OSC_CTRL, d);
        check(d, 16'h0000);
        check({bext, funs}, 2'h0);
        rd(RBCS_ADDR_BOOT, d);
        check(d, 16'h0000);
    endtask

    task automatic t_regs();
        wr(RBCS_ADDR_PUDR, 16'h0007);
        check({pu_r, pu_b, pu_e}, 3'h0);
        rd(RBCS_ADDR_PUDR, d);
        check(d, 16'h0007);
        wr(RBCS_ADDR_OSC_CTRL, 16'h0001);
        check(osc, 1'b1);
        rd(RBCS_ADDR_OSC_CTRL, d);
        check(d, 16'h0001);
        wr(RBCS_ADDR_OSC_CTRL, 16'h0000);
        check(osc, 1'b0);
        wr(4'h5, 16'hffff);
        rd(4'h4, d);
        check(d, 16'h0000);
        rd(RBCS_ADDR_PUDR, d);
        check(d, 16'h0007);
    endtask

    task automatic t_debug_boot();
        @(posedge clk_i);
        sec <= 1'b0;
        @(posedge clk_i);
        #1 check(funs, 1'b0);
        @(posedge clk_i);
        dbg <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1 check({pu_r, pu_b, pu_e, rso}, 4'hf);
        wr(RBCS_ADDR_OSC_CTRL, 16'h0001);
        check(osc, 1'b0);
        release_all();
        check(16'(n), 16'(RC + 3));
        rd(RBCS_ADDR_STAT, d);
        check(d, 16'h0007);
        check({bext, funs}, 2'h1);
        rd(RBCS_ADDR_BOOT, d);
        check(d, 16'h0002);
    endtask

    task automatic end_of_test();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        t_power_up();
        t_regs();
        t_debug_boot();
        end_of_test();
    end
endmodule // rbcs_core_tb
`default_nettype wire
